// *** rtl/pdsc_defines.svh ***
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PDSC_ADDR_W          4
`define PDSC_OFS_CTRL_ONE    4'h0
`define PDSC_OFS_STATUS      4'h1
`define PDSC_OFS_WAIT_CNT    4'h2

// ----------------------------------------
// Control field positions and reset
// ----------------------------------------
`define PDSC_BIT_STBY        7
`define PDSC_WAIT_HI         6
`define PDSC_WAIT_LO         4
`define PDSC_BIT_NSEL        3
`define PDSC_CTRL_RST        8'h00
`define PDSC_CTRL_WMASK      8'hF8

// ----------------------------------------
// Wake wait lengths in system clock states
// ----------------------------------------
`define PDSC_CNT_W           18
`define PDSC_WAIT_0          18'h02000
`define PDSC_WAIT_1          18'h04000
`define PDSC_WAIT_2          18'h08000
`define PDSC_WAIT_3          18'h10000
`define PDSC_WAIT_4          18'h20000
`define PDSC_WAIT_5          18'h00400
`define PDSC_WAIT_6          18'h00080
`define PDSC_WAIT_7          18'h00010

// ----------------------------------------
// Sample divider terminal counts (divide ratio minus one)
// ----------------------------------------
`define PDSC_DIV_SLOW        4'hF
`define PDSC_DIV_FAST        4'h3

`endif

// *** rtl/pdsc_pkg.sv ***
package pdsc_pkg;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [4:0] {
    PDSC_ACTIVE   = 5'h01,
    PDSC_SLEEP    = 5'h02,
    PDSC_SUBSLEEP = 5'h04,
    PDSC_STANDBY  = 5'h08,
    PDSC_WAKEWAIT = 5'h10
  } pdsc_mode_t;

endpackage : pdsc_pkg

// *** rtl/pdsc_wake_timer.sv ***
`timescale 1ns/1ns
`include "pdsc_defines.svh"

module pdsc_wake_timer
  (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     start,
    input  wire logic [2:0]               sel,
    output logic                          busy,
    output logic                          done,
    output logic [`PDSC_CNT_W-1:0]        count
  );

  // ----------------------------------------
  // Wait length lookup
  // ----------------------------------------
  function automatic logic [`PDSC_CNT_W-1:0] wait_len
    (input logic [2:0] s);
    case (s)
      3'h0:    wait_len = `PDSC_WAIT_0;
      3'h1:    wait_len = `PDSC_WAIT_1;
      3'h2:    wait_len = `PDSC_WAIT_2;
      3'h3:    wait_len = `PDSC_WAIT_3;
      3'h4:    wait_len = `PDSC_WAIT_4;
      3'h5:    wait_len = `PDSC_WAIT_5;
      3'h6:    wait_len = `PDSC_WAIT_6;
      default: wait_len = `PDSC_WAIT_7;
    endcase
  endfunction : wait_len

  logic [`PDSC_CNT_W-1:0] limit_q;

  // R4: length latched at start
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_q <= '0;
    else if (start)
      limit_q <= wait_len(sel);
  end

  // R12: count states then done
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy  <= 1'b1;
        count <= '0;
      end
      else if (busy)
      begin
        if (count + 1'b1 == limit_q)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count + 1'b1;
      end
    end
  end

endmodule : pdsc_wake_timer

// *** rtl/pdsc_top.sv ***
// How it works
// R1: Sleep instruction with standby select 0 enters sleep or subsleep.
// R2: Sleep instruction with standby select 1 enters standby.
// R3: Bits 6..4 set the stable clock wait after an interrupt wake.
// R4: Codes 0..7 give 8192,16384,32768,65536,131072,1024,128,16 states.
// R5: Software picks a wait of at least 6.5 ms for its clock.
// R6: With an external clock software should program all wait bits to 1.
// R7: Sample rate bit 0 gives oscillator/16, 1 gives oscillator/4.
// R8: Software keeps sample rate bit 0 for a 2 to 10 MHz oscillator.
// R9: Bits 2..0 read as zero and ignore writes.
// R10: Standby halts CPU and peripherals, only time base may run.
// R11: Reset clears the whole control register.
// R12: After a wake interrupt the states are counted before release.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "pdsc_defines.svh"

module pdsc_top
  (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic [`PDSC_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    sleep_exec,
    input  wire logic                    sub_clock_sel,
    input  wire logic                    wake_irq,
    input  wire logic                    time_base_en,
    output logic                         cpu_run,
    output logic                         periph_run,
    output logic                         time_base_run,
    output logic                         standby_out,
    output logic                         watch_sample
  );

  // ----------------------------------------
  // Pin synchroniser for the wake interrupt
  // ----------------------------------------
  logic [1:0] irq_sync_q;
  logic       irq_s;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_sync_q <= 2'b00;
    else
      irq_sync_q <= {irq_sync_q[0], wake_irq};
  end
  assign irq_s = irq_sync_q[1];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit
    (
      input logic [`PDSC_ADDR_W-1:0] addr,
      input logic [`PDSC_ADDR_W-1:0] ofs
    );
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic       stby_sel;
  logic [2:0] wait_sel;
  logic       nsel;

  // R11: reset clears all fields
  // R9: reserved bits never stored
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `PDSC_CTRL_RST;
    else if (reg_wr && addr_hit(reg_addr, `PDSC_OFS_CTRL_ONE))
      ctrl_q <= reg_wdata & `PDSC_CTRL_WMASK;
  end

  assign stby_sel = ctrl_q[`PDSC_BIT_STBY];
  assign wait_sel = ctrl_q[`PDSC_WAIT_HI:`PDSC_WAIT_LO];
  assign nsel     = ctrl_q[`PDSC_BIT_NSEL];

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  pdsc_pkg::pdsc_mode_t mode_q;
  logic                 tmr_start;
  logic                 tmr_busy;
  logic                 tmr_done;
  logic [`PDSC_CNT_W-1:0] tmr_count;

  assign tmr_start = irq_s &&
                     (mode_q == pdsc_pkg::PDSC_STANDBY ||
                      mode_q == pdsc_pkg::PDSC_SUBSLEEP);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= pdsc_pkg::PDSC_ACTIVE;
    else
    begin
      case (mode_q)
        pdsc_pkg::PDSC_ACTIVE:
        begin
          if (sleep_exec)
          begin
            // R2: standby chosen
            if (stby_sel)
              mode_q <= pdsc_pkg::PDSC_STANDBY;
            // R1: sleep or subsleep
            else if (sub_clock_sel)
              mode_q <= pdsc_pkg::PDSC_SUBSLEEP;
            else
              mode_q <= pdsc_pkg::PDSC_SLEEP;
          end
        end
        pdsc_pkg::PDSC_SLEEP:
        begin
          if (irq_s)
            mode_q <= pdsc_pkg::PDSC_ACTIVE;
        end
        pdsc_pkg::PDSC_SUBSLEEP,
        pdsc_pkg::PDSC_STANDBY:
        begin
          // R3: interrupt wake waits
          if (irq_s)
            mode_q <= pdsc_pkg::PDSC_WAKEWAIT;
        end
        pdsc_pkg::PDSC_WAKEWAIT:
        begin
          // R12: release after count
          if (tmr_done)
            mode_q <= pdsc_pkg::PDSC_ACTIVE;
        end
        default: mode_q <= pdsc_pkg::PDSC_ACTIVE;
      endcase
    end
  end

  // R3 R4: wait field to timer
  pdsc_wake_timer u_timer
    (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .start   (tmr_start),
      .sel     (wait_sel),
      .busy    (tmr_busy),
      .done    (tmr_done),
      .count   (tmr_count)
    );

  // ----------------------------------------
  // Run enables
  // ----------------------------------------
  // R10: standby halts all but time base
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_run       <= 1'b0;
      periph_run    <= 1'b0;
      time_base_run <= 1'b0;
      standby_out   <= 1'b0;
    end
    else
    begin
      cpu_run       <= (mode_q == pdsc_pkg::PDSC_ACTIVE);
      periph_run    <= (mode_q == pdsc_pkg::PDSC_ACTIVE) ||
                       (mode_q == pdsc_pkg::PDSC_SLEEP)  ||
                       (mode_q == pdsc_pkg::PDSC_SUBSLEEP);
      time_base_run <= time_base_en;
      standby_out   <= (mode_q == pdsc_pkg::PDSC_STANDBY);
    end
  end

  // ----------------------------------------
  // Watch clock sample strobe
  // ----------------------------------------
  logic [3:0] div_q;

  // R7: divide by 16 or by 4
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q        <= 4'h0;
      watch_sample <= 1'b0;
    end
    else if (div_q >= (nsel ? `PDSC_DIV_FAST : `PDSC_DIV_SLOW))
    begin
      div_q        <= 4'h0;
      watch_sample <= 1'b1;
    end
    else
    begin
      div_q        <= div_q + 4'h1;
      watch_sample <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    // R9: low bits read zero
    else if (addr_hit(reg_addr, `PDSC_OFS_CTRL_ONE))
      reg_rdata <= ctrl_q;
    else if (addr_hit(reg_addr, `PDSC_OFS_STATUS))
      reg_rdata <= {2'b00, tmr_busy, mode_q};
    else if (addr_hit(reg_addr, `PDSC_OFS_WAIT_CNT))
      reg_rdata <= tmr_count[`PDSC_CNT_W-1:`PDSC_CNT_W-8];
    else
      reg_rdata <= 8'h00;
  end

endmodule : pdsc_top

// *** sim/pdsc_checker_assertions.sv ***
`timescale 1ns/1ns

module pdsc_checker
  (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sleep_exec,
    input wire logic       time_base_en,
    input wire logic       cpu_run,
    input wire logic       periph_run,
    input wire logic       time_base_run,
    input wire logic       standby_out,
    input wire logic       watch_sample
  );
  localparam int WL[8] = '{8192, 16384, 32768, 65536, 131072, 1024, 128, 16};
  logic [7:3] ctl_q;
  logic       woke_q;
  int         cnt_q;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Control shadow and wake counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q  <= '0;
      woke_q <= 1'b0;
      cnt_q  <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == 4'h0)
        ctl_q <= reg_wdata[7:3];
      woke_q <= standby_out || (woke_q && !cpu_run);
      cnt_q  <= standby_out ? 0 : cnt_q + 1;
    end
  end

  sleep_entry_a: assert property (sleep_exec && cpu_run && !ctl_q[7] |->
    ##[1:3] (periph_run && !cpu_run && !standby_out)) else $error("sleep");
  standby_entry_a: assert property (sleep_exec && cpu_run && ctl_q[7] |->
    ##[1:3] standby_out) else $error("standby");
  standby_halt_a: assert property (standby_out && $past(standby_out) |->
    !cpu_run && !periph_run) else $error("halt");
  time_base_a: assert property ($past(rst_n) |->
    time_base_run == $past(time_base_en)) else $error("time base");
  ctrl_readback_a: assert property (reg_rd && reg_addr == 4'h0 |=>
    reg_rdata == {ctl_q, 3'h0}) else $error("readback");
  wake_wait_a: assert property (woke_q && $rose(cpu_run) |->
    cnt_q >= WL[ctl_q[6:4]] - 1 && cnt_q <= WL[ctl_q[6:4]] + 8)
    else $error("wake wait");
  fast_sample_a: assert property (disable iff (!rst_n || !cpu_run)
    watch_sample && ctl_q[3] && $past(ctl_q[3], 16) |=>
    (!watch_sample [*3] ##1 watch_sample) or (##[0:2] !ctl_q[3]))
    else $error("fast sample");
  slow_sample_a: assert property (disable iff (!rst_n || !cpu_run)
    watch_sample && !ctl_q[3] && !$past(ctl_q[3], 16) |=>
    (!watch_sample [*8] ##1 !watch_sample [*7] ##1 watch_sample) or
    (##[0:14] ctl_q[3]))
    else $error("slow sample");
endmodule : pdsc_checker

bind pdsc_top pdsc_checker chk_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .time_base_en, .cpu_run,
  .periph_run, .time_base_run, .standby_out, .watch_sample);

// *** sim/testbench.sv ***
`timescale 1ns/1ns

module testbench;
  logic       sys_clk, rst_n, reg_wr, reg_rd, sleep_exec;
  logic       sub_clock_sel, wake_irq, time_base_en;
  logic       cpu_run, periph_run, time_base_run, standby_out, watch_sample;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         miscompares = 0, n_compared = 0, cyc = 0, n;
  int         wl[5] = '{8192, 16384, 1024, 128, 16};
  logic [2:0] cd[5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};

  pdsc_top dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_exec, .sub_clock_sel, .wake_irq, .time_base_en,
    .cpu_run, .periph_run, .time_base_run, .standby_out, .watch_sample);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge sys_clk);
  endtask : tick

  task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask : wr

  task automatic rd(logic [3:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    tick();
    chk("rdata", e, reg_rdata);
  endtask : rd

  task automatic rate(int len, int e);
    n = 0;
    repeat (len)
    begin
      tick();
      n += watch_sample;
    end
    chk("sample rate", 18'(e), 18'(n));
  endtask : rate

  task automatic sleep_op();
    sleep_exec <= 1'b1;
    tick();
    sleep_exec <= 1'b0;
    repeat (4) tick();
  endtask : sleep_op

  task automatic wake(int lim);
    wake_irq <= 1'b1;
    n = 0;
    while (cpu_run !== 1'b1 && n < lim)
    begin
      tick();
      n++;
    end
    wake_irq <= 1'b0;
    tick();
  endtask : wake

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, reg_wr, reg_rd, sleep_exec, sub_clock_sel} = '0;
    {wake_irq, time_base_en, reg_addr, reg_wdata} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) tick();
    chk("cpu_run", 1'b1, cpu_run);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h01);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'hF8);
    rd(4'hF, 8'h00);
    rst_n <= 1'b0;
    repeat (3) tick();
    rst_n <= 1'b1;
    tick();
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h08);
    repeat (8) tick();
    rate(40, 10);
    time_base_en <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h0, {1'b1, cd[i], 4'h0});
      sleep_op();
      chk("standby", 1'b1, standby_out);
      chk("halt", 1'b0, cpu_run | periph_run);
      chk("tbase", 1'b1, time_base_run);
      wake(wl[i] + 50);
      chk("wait", 1'b1, n >= wl[i] && n <= wl[i] + 10);
    end
    for (int i = 0; i < 2; i++)
    begin
      sub_clock_sel <= i[0];
      wr(4'h0, 8'h70);
      sleep_op();
      chk("sleep", 2'h1, {cpu_run, periph_run});
      rd(4'h1, i ? 8'h04 : 8'h02);
      wake(200);
      chk("wake", 1'b1, cpu_run);
    end
    rate(32, 2);
    tally_and_finish();
  end
endmodule : testbench
